// ==== tb/tid_data_irq_properties.sv ====
// Port checks of the data and interrupt enable block.
`timescale 1ns/1ps
module tid_data_irq_properties
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire tid_pkg::tid_events_t events,
  input wire tid_pkg::tid_cmd_t cmd,
  input wire logic irq
);
  // ----
  // Checks
  // ----
  // Transfers never overlap here, so a past address phase names its own access.
  wire take = hsel && hready && htrans[1];
  wire dat = take && haddr == 32'ha0;
  wire wset = take && hwrite && haddr == 32'h58;
  wire wclr = take && hwrite && (haddr == 32'h50 || haddr == 32'h60);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bad resp");
  wait_cause_a: assert property (!hreadyout |-> $past(take))
    else $error("stray wait");
  wait_single_a: assert property (!hreadyout |=> hreadyout)
    else $error("long wait");
  cmd_cause_a: assert property (cmd.valid |-> $past(dat, 2) || $past(dat, 3))
    else $error("stray command");
  cmd_kind_a:
    assert property (cmd.valid |-> (cmd.op == tid_pkg::TID_OP_TX) ==
      ($past(dat && hwrite, 2) || $past(dat && hwrite, 3))) else $error("wrong op");
  irq_rise_a: assert property ($rose(irq) |-> $past(|events) || $past(wset, 2))
    else $error("irq rose alone");
  irq_fall_a: assert property ($fell(irq) |-> $past(wclr, 2))
    else $error("irq fell alone");
  irq_hold_a: assert property (irq && !wclr && !$past(wclr) |=> irq)
    else $error("irq dropped");
endmodule // tid_data_irq_properties
bind tid_data_irq tid_data_irq_properties props (.*);

// ==== tb/tid_data_irq_test.sv ====
// Self-checking bench of the data and interrupt enable block.
`timescale 1ns/1ps
module tid_data_irq_test;
  logic hclk, hresetn, hwrite, rdy, irq, hold, st, sp, rxv;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, d, rdat;
  logic [7:0] rxb;
  tid_pkg::tid_events_t req, ev;
  tid_pkg::tid_cmd_t cmd, last;
  int n_fail = 0;
  int checks_done = 0;
  int waits = 0;
  integer seed = 32'he08e;
  logic [31:0] ens [3] = '{32'h80, 32'h2, 32'h1};
  tid_pkg::tid_events_t evs [3] = '{3'b100, 3'b010, 3'b001};
  tid_data_irq DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
    .hreadyout(rdy), .hresp(), .clock_stretch_status(st), .stop_seen(sp), .rx_byte(rxb),
    .rx_byte_valid(rxv), .events(ev), .cmd(cmd), .irq(irq));
  tid_node_model node (.hclk(hclk), .hresetn(hresetn), .cmd(cmd), .hold(hold), .req(req),
    .stretch(st), .stop(sp), .rxb(rxb), .rxv(rxv), .ev(ev), .last(last));
  function automatic logic [31:0] rx_of(input logic [31:0] w);
    return {24'h0, ~w[7:0]};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Levels are looked at on the falling edge, where nothing is moving.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(negedge hclk); while (rdy !== 1'b1);
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= v;
    @(negedge hclk);
    while (rdy !== 1'b1)
    begin
      waits += int'(w);
      @(negedge hclk);
    end
    @(posedge hclk);
    rdat = hrdata;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    @(negedge hclk);
    cmp(rdat, e);
    @(posedge hclk);
  endtask
  task automatic pulse(input tid_pkg::tid_events_t e, input logic x);
    req <= e;
    @(posedge hclk);
    req <= 3'b000;
    repeat (2) @(negedge hclk);
    cmp(32'(irq), 32'(x));
    @(posedge hclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial
  begin
    #10000;
    n_fail++;
    stop_test;
  end
  initial
  begin
    hresetn = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hold = 1'b0;
    req = 3'b000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(32'h58, 32'h0);
    chk(32'ha0, 32'h0);
    chk(32'h3fc, 32'h0);
    d = $random(seed);
    xfer(1'b1, 32'h58, d);
    xfer(1'b1, 32'h58, 32'h0);
    chk(32'h50, d & 32'h83);
    xfer(1'b1, 32'h50, 32'hff);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, 32'h58, ens[i]);
      chk(32'h50, ens[i]);
      pulse(~evs[i], 1'b0);
      pulse(evs[i], 1'b1);
      xfer(1'b1, 32'h60, 32'hff);
      xfer(1'b1, 32'h50, ens[i]);
    end
    hold <= 1'b1;
    repeat (4) @(posedge hclk);
    d = $random(seed);
    xfer(1'b1, 32'ha0, d);
    repeat (2) @(posedge hclk);
    cmp(32'(last), {21'h0, 1'b1, tid_pkg::TID_OP_TX, d[7:0]});
    for (int a = 0; a < 2; a++)
    begin
      xfer(1'b1, 32'h10, 32'(a) << 18);
      chk(32'ha0, rx_of(d));
      repeat (2) @(posedge hclk);
      cmp(32'(last.op), (a == 1) ? 32'h3 : 32'h1);
    end
    cmp(32'(waits), 32'h0);
    xfer(1'b1, 32'h10, 32'h100);
    d = $random(seed);
    xfer(1'b1, 32'ha0, d);
    cmp(32'(waits), 32'h1);
    hold <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'ha0, rx_of(d));
    repeat (3) @(posedge hclk);
    cmp(32'(last.op), 32'h2);
    stop_test;
  end
endmodule // tid_data_irq_test

// ==== tb/tid_node_model.sv ====
// Behavioural model of a far-side two-wire node.
`timescale 1ns/1ps
module tid_node_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire tid_pkg::tid_cmd_t cmd,
  input wire logic hold,
  input wire tid_pkg::tid_events_t req,
  output logic stretch,
  output logic stop,
  output logic [7:0] rxb,
  output logic rxv,
  output tid_pkg::tid_events_t ev,
  output tid_pkg::tid_cmd_t last
);
  // ----
  // Node
  // ----
  assign stretch = hold;
  assign stop = !hold;
  // Each sent byte is answered with its complement, so both buffers carry traffic.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ev <= '0;
      last <= '0;
      rxb <= 8'h00;
      rxv <= 1'b0;
    end
    else
    begin
      ev <= req;
      rxv <= cmd.valid && cmd.op == tid_pkg::TID_OP_TX;
      rxb <= cmd.valid ? ~cmd.data : rxb;
      last <= cmd.valid ? cmd : last;
    end
endmodule // tid_node_model

// ==== verilog/tid_data_irq.sv ====
// Data register and interrupt enable logic of the two-wire interface with AHB-Lite slave.
// ----------------------------------------------------------------
// Overview of operation
// (RULE1) Eight-bit data field reaches transmit and receive buffers.
// (RULE2) Software accesses data only while clock stretched.
// (RULE3) Last byte readable after stop, clock released.
// (RULE4) Each data access triggers an operation on the bus.
// (RULE5) Smart mode synchronises data accesses; otherwise immediate.
// (RULE6) Enable set register: ones set, zeros ignored.
// (RULE7) Set and clear views share one enable.
// (RULE8) Bit 7 is the error interrupt enable.
// (RULE9) Bit 1 is the slave on bus enable.
// (RULE10) Bit 0 is the master on bus enable.
// (RULE11) Interrupt asserted when flagged event is enabled.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module tid_data_irq
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic clock_stretch_status,
  input wire logic stop_seen,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire tid_pkg::tid_events_t events,
  output tid_pkg::tid_cmd_t cmd,
  output logic irq
);

  // ----------------------------------------------------------------
  // Synchronised link status
  // ----------------------------------------------------------------
  // Status comes from the bus side logic, so it crosses two flops first.
  logic [1:0] link_sync;

  tid_sync #(.W(2)) u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({clock_stretch_status, stop_seen}),
    .q(link_sync)
  );

  wire stretch_s = link_sync[1];
  wire stop_s = link_sync[0];

  // ----------------------------------------------------------------
  // AHB-Lite address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] idx_r;
  logic smart_hold_r;

  wire addr_take = hsel && hready && htrans[1];
  wire [7:0] idx_in = haddr[9:2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_take && hwrite;
      rd_pend_r <= addr_take && !hwrite;
      idx_r <= idx_in;
    end
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire hit_set = idx_r == tid_pkg::IDX_IRQ_ENABLE_SET;
  wire hit_clr = idx_r == tid_pkg::IDX_IRQ_ENABLE_CLEAR;
  wire hit_stat = idx_r == tid_pkg::IDX_IRQ_STATUS;
  wire hit_ctrl = idx_r == tid_pkg::IDX_CONTROL_B;
  wire hit_link = idx_r == tid_pkg::IDX_LINK_STATUS;
  wire hit_data = idx_r == tid_pkg::IDX_BUS_DATA;

  logic [31:0] control_b_r;
  wire smart_mode_enable = control_b_r[tid_pkg::BIT_SMART_MODE];
  wire acknowledge_action = control_b_r[tid_pkg::BIT_ACK_ACTION];

  // Smart-mode data writes wait one extra cycle for the synchronised view; smart-mode data reads wait only the one cycle every read waits.
  // Every read waits one cycle as well, so registered read data stands in the data phase.
  wire data_acc = (wr_pend_r || rd_pend_r) && hit_data;
  wire smart_wait = data_acc && smart_mode_enable; // see (RULE5)
  wire stall = (smart_wait || rd_pend_r) && !smart_hold_r;
  wire wr_go = wr_pend_r && !stall;
  wire rd_go = rd_pend_r && !stall;

  assign hreadyout = !stall;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      smart_hold_r <= 1'b0;
    else
      smart_hold_r <= stall;
  end

  // ----------------------------------------------------------------
  // Control and enable registers
  // ----------------------------------------------------------------
  logic [7:0] irq_en_r;
  logic [7:0] irq_en_nxt;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_stat_nxt;
  logic [7:0] ev_vec;

  wire [7:0] wbits = hwdata[7:0] & tid_pkg::IRQ_FIELD_MASK;

  // One enable register serves both the set and the clear view.
  assign irq_en_nxt = (wr_go && hit_set) ? (irq_en_r | wbits) : // see (RULE6) (RULE7)
    (wr_go && hit_clr) ? (irq_en_r & ~wbits) : irq_en_r;

  assign ev_vec = {events.error, 5'h00, events.slave_on_bus, events.master_on_bus};
  // A new event wins over a write-one clear in the same cycle.
  assign irq_stat_nxt = ((wr_go && hit_stat) ? (irq_stat_r & ~wbits) : irq_stat_r) | ev_vec;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_en_r <= tid_pkg::RESET_IRQ_ENABLE;
      irq_stat_r <= tid_pkg::RESET_IRQ_ENABLE;
      control_b_r <= tid_pkg::RESET_CONTROL_B;
    end
    else
    begin
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      if (wr_go && hit_ctrl)
        control_b_r <= hwdata;
    end
  end

  // Error, slave-on-bus and master-on-bus gating.
  wire err_on = irq_stat_r[tid_pkg::BIT_ERROR] && irq_en_r[tid_pkg::BIT_ERROR]; // see (RULE8)
  wire sb_on = irq_stat_r[tid_pkg::BIT_SLAVE_ON_BUS] &&
    irq_en_r[tid_pkg::BIT_SLAVE_ON_BUS]; // see (RULE9)
  wire mb_on = irq_stat_r[tid_pkg::BIT_MASTER_ON_BUS] &&
    irq_en_r[tid_pkg::BIT_MASTER_ON_BUS]; // see (RULE10)
  assign irq = err_on || sb_on || mb_on; // see (RULE11)

  // ----------------------------------------------------------------
  // Receive holding byte
  // ----------------------------------------------------------------
  // The byte stays held after a stop, so the last one is still readable.
  logic [7:0] rx_hold_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_hold_r <= tid_pkg::RESET_BUS_DATA[7:0];
    else if (rx_byte_valid)
      rx_hold_r <= rx_byte; // see (RULE1) (RULE3)
  end

  // ----------------------------------------------------------------
  // Bus operation launch
  // ----------------------------------------------------------------
  // Accesses outside a clock stretch are accepted but launch nothing;
  // a read after stop still returns the held byte.
  wire data_ok = stretch_s; // see (RULE2)
  wire launch_wr = wr_go && hit_data && data_ok;
  wire launch_rd = rd_go && hit_data && data_ok && !stop_s;
  tid_pkg::tid_op_t op_sel;

  assign op_sel = launch_wr ? tid_pkg::TID_OP_TX :
    (acknowledge_action ? tid_pkg::TID_OP_RX_NACK : tid_pkg::TID_OP_RX_ACK); // see (RULE4)

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd <= '0;
    else
    begin
      cmd.valid <= launch_wr || launch_rd; // see (RULE4)
      cmd.op <= (launch_wr || launch_rd) ? op_sel : tid_pkg::TID_OP_NONE;
      cmd.data <= launch_wr ? hwdata[7:0] : cmd.data; // see (RULE1)
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_set || hit_clr)
      rd_mux = {24'h0, irq_en_r}; // see (RULE7)
    else if (hit_stat)
      rd_mux = {24'h0, irq_stat_r};
    else if (hit_ctrl)
      rd_mux = control_b_r;
    else if (hit_link)
      rd_mux = {24'h0, stretch_s, stop_s, 6'h00};
    else if (hit_data)
      rd_mux = {24'h0, rx_hold_r}; // see (RULE1) (RULE3)
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_take && !hwrite)
      hrdata <= 32'h0000_0000;
    else if (rd_pend_r && stall)
      hrdata <= rd_mux;
  end

endmodule // tid_data_irq

// ==== verilog/tid_pkg.sv ====
// Package with register map, field positions and shared types of the two-wire data block.
package tid_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h16;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
  localparam logic [7:0] IDX_CONTROL_B = 8'h04;
  localparam logic [7:0] IDX_LINK_STATUS = 8'h1a;
  localparam logic [7:0] IDX_BUS_DATA = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_ERROR = 7;
  localparam int BIT_SLAVE_ON_BUS = 1;
  localparam int BIT_MASTER_ON_BUS = 0;
  localparam logic [7:0] IRQ_FIELD_MASK = 8'h83;
  localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
  localparam logic [15:0] RESET_BUS_DATA = 16'h0000;
  localparam int BIT_ACK_ACTION = 18;
  localparam int BIT_SMART_MODE = 8;
  localparam logic [31:0] RESET_CONTROL_B = 32'h0000_0000;
  localparam int BIT_CLOCK_STRETCH = 7;
  localparam int BIT_STOP_SEEN = 6;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TID_OP_NONE = 2'b00,
    TID_OP_RX_ACK = 2'b01,
    TID_OP_RX_NACK = 2'b11,
    TID_OP_TX = 2'b10
  } tid_op_t;

  typedef struct packed {
    logic valid;
    tid_op_t op;
    logic [7:0] data;
  } tid_cmd_t;

  typedef struct packed {
    logic error;
    logic slave_on_bus;
    logic master_on_bus;
  } tid_events_t;

  function automatic logic [31:0] idx_to_addr(input logic [7:0] idx);
    idx_to_addr = {22'h0, idx, 2'b00};
  endfunction

endpackage

// ==== verilog/tid_sync.sv ====
// Two flip-flop synchroniser for a group of level signals.
`timescale 1ns/1ps
module tid_sync
#(
  parameter int W = 1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // tid_sync
